//--- logic/cpsm_monitor.sv
/*
  Clock and power status monitor registers at offsets 0x67 to 0x6a.
  Holds the register port, the auto or programmed selection of the clock
  settings in use, and synchronised power status of analog sub-blocks.
  Assumes a control port engine on clk issues one-cycle read and write
  strobes, and that clock settings and the PLL enable come from logic on clk.
  Power status levels come from analog circuits and are synchronised here.
*/
`include "cpsm_consts.svh"
`default_nettype none

module cpsm_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire cpsm_pkg::cpsm_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic auto_clock_en,
  input wire cpsm_pkg::cpsm_clk_cfg_t auto_cfg,
  input wire cpsm_pkg::cpsm_clk_cfg_t manual_cfg,
  input wire logic pll_enable,
  input wire cpsm_pkg::cpsm_pwr_t pwr_async,
  output cpsm_pkg::cpsm_clk_cfg_t cfg_in_use,
  output logic pll_on_status
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////////

  cpsm_pkg::cpsm_clk_cfg_t cfg_in_use_ff; // Settings actually applied
  cpsm_pkg::cpsm_pwr_t pwr_live_ff; // Synchronised power status
  logic pll_on_ff; // PLL enable as applied
  logic rsv_pump_ff; // Reserved read/write bit 7 at 0x67
  logic rsv_osr_ff; // Reserved read/write bit 7 at 0x68
  logic [2:0] rsv_pll_hi_ff; // Reserved read/write bits 7-5 at 0x69
  logic rsv_pll_lo_ff; // Reserved read/write bit 3 at 0x69
  logic [7:0] rdata_ff; // Read data held for the port
  logic rvalid_ff; // Read answer strobe
  logic [7:0] nxt_rdata; // Byte selected by the read offset
  logic rd_go; // Read accepted this cycle
  logic wr_go; // Write accepted this cycle

  ////////////////////////////////////////////////////////////////////////////
  // Clock settings in use
  ////////////////////////////////////////////////////////////////////////////

  // Pump divider: auto value while auto set is on
  cpsm_src_select #(
    .WIDTH(7),
    .RST_VAL(`CPSM_RST_DIV)
  ) u_pump_sel (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .auto_en(auto_clock_en),
    .auto_val(auto_cfg.pump_divider_in_use),
    .manual_val(manual_cfg.pump_divider_in_use),
    .in_use_ff(cfg_in_use_ff.pump_divider_in_use)
  );

  // Oversample divider: auto value while auto set is on
  cpsm_src_select #(
    .WIDTH(7),
    .RST_VAL(`CPSM_RST_DIV)
  ) u_osr_sel (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .auto_en(auto_clock_en),
    .auto_val(auto_cfg.oversample_divider_in_use),
    .manual_val(manual_cfg.oversample_divider_in_use),
    .in_use_ff(cfg_in_use_ff.oversample_divider_in_use)
  );

  // PLL reference: auto choice while auto set is on
  cpsm_src_select #(
    .WIDTH(3),
    .RST_VAL(`CPSM_RST_SRC)
  ) u_src_sel (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .auto_en(auto_clock_en),
    .auto_val(auto_cfg.pll_source_in_use),
    .manual_val(manual_cfg.pll_source_in_use),
    .in_use_ff(cfg_in_use_ff.pll_source_in_use)
  );

  // Track the PLL enable as applied
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pll_on_ff <= 1'b0;
    end else if (clk_en) begin
      pll_on_ff <= pll_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power status synchroniser
  ////////////////////////////////////////////////////////////////////////////

  // Analog status levels cross into clk here
  cpsm_pin_sync #(
    .WIDTH(8)
  ) u_pwr_sync (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in(pwr_async),
    .level_ff(pwr_live_ff)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  ////////////////////////////////////////////////////////////////////////////

  // Strobes only count while the clock enable is high
  assign rd_go = clk_en && reg_req.rd;
  assign wr_go = clk_en && reg_req.wr;

  // Reserved read/write bits store writes; monitor fields take none
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsv_pump_ff <= `CPSM_RST_RSV_BIT;
      rsv_osr_ff <= `CPSM_RST_RSV_BIT;
      rsv_pll_hi_ff <= `CPSM_RST_RSV_HI;
      rsv_pll_lo_ff <= `CPSM_RST_RSV_BIT;
    end else if (wr_go) begin
      case (reg_req.addr)
        `CPSM_OFS_PUMP_DIV: begin
          rsv_pump_ff <= reg_req.wdata[`CPSM_DIV_RSV_BIT];
        end
        `CPSM_OFS_OSR_DIV: begin
          rsv_osr_ff <= reg_req.wdata[`CPSM_DIV_RSV_BIT];
        end
        `CPSM_OFS_PLL: begin
          rsv_pll_hi_ff <= reg_req.wdata[`CPSM_PLL_RSV_HI_MSB:`CPSM_PLL_RSV_HI_LSB];
          rsv_pll_lo_ff <= reg_req.wdata[`CPSM_PLL_RSV_LO_BIT];
        end
        default: begin
          // Power monitor and unmapped offsets ignore writes
        end
      endcase
    end
  end

  // Select the read byte from live state
  always_comb begin
    nxt_rdata = `CPSM_RD_UNMAPPED;
    case (reg_req.addr)
      `CPSM_OFS_PUMP_DIV: begin
        nxt_rdata = {rsv_pump_ff, cfg_in_use_ff.pump_divider_in_use};
      end
      `CPSM_OFS_OSR_DIV: begin
        nxt_rdata = {rsv_osr_ff, cfg_in_use_ff.oversample_divider_in_use};
      end
      `CPSM_OFS_PLL: begin
        nxt_rdata = {rsv_pll_hi_ff, pll_on_ff, rsv_pll_lo_ff,
                     cfg_in_use_ff.pll_source_in_use};
      end
      `CPSM_OFS_PWR: begin
        // Bits 7..0 map pump, reference, driver, bias, feedback, left,
        // right, converter
        nxt_rdata = pwr_live_ff;
      end
      default: begin
        nxt_rdata = `CPSM_RD_UNMAPPED;
      end
    endcase
  end

  // Capture the byte at the read, so it is the status of that moment
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= `CPSM_RST_BYTE;
    end else if (rd_go) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Answer strobe one cycle after each accepted read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_ff <= 1'b0;
    end else if (clk_en) begin
      rvalid_ff <= reg_req.rd;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign cfg_in_use = cfg_in_use_ff;
  assign pll_on_status = pll_on_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Read of a given offset, accepted this cycle
  sequence s_read(logic [7:0] ofs);
    rd_go && (reg_req.addr == ofs);
  endsequence

  // Power inputs held still over six enabled cycles
  sequence s_pwr_settled;
    (clk_en && $stable(pwr_async))[*6];
  endsequence

  // Write of a given offset, accepted this cycle
  sequence s_write(logic [7:0] ofs);
    wr_go && (reg_req.addr == ofs);
  endsequence

  chk_pump_auto_pick: assert property (
    $past(rst_b) && $past(clk_en) |-> cfg_in_use_ff.pump_divider_in_use ==
      ($past(auto_clock_en) ? $past(auto_cfg.pump_divider_in_use)
                            : $past(manual_cfg.pump_divider_in_use)))
    else $error("pump divider in use does not follow auto set");

  chk_src_auto_pick: assert property (
    $past(rst_b) && $past(clk_en) |-> cfg_in_use_ff.pll_source_in_use ==
      ($past(auto_clock_en) ? $past(auto_cfg.pll_source_in_use)
                            : $past(manual_cfg.pll_source_in_use)))
    else $error("pll source in use does not follow auto set");

  chk_pump_div_read: assert property (
    s_read(`CPSM_OFS_PUMP_DIV) |=> reg_rvalid &&
      (reg_rdata[`CPSM_DIV_MSB:0] == $past(cfg_in_use_ff.pump_divider_in_use)))
    else $error("pump divider read wrong");

  chk_osr_div_read: assert property (
    s_read(`CPSM_OFS_OSR_DIV) |=> reg_rvalid &&
      (reg_rdata[`CPSM_DIV_MSB:0] == $past(cfg_in_use_ff.oversample_divider_in_use)))
    else $error("oversample divider read wrong");

  chk_pll_state_read: assert property (
    s_read(`CPSM_OFS_PLL) |=>
      (reg_rdata[`CPSM_PLL_ON_BIT] == $past(pll_enable, 2)) &&
      (reg_rdata[`CPSM_PLL_SRC_MSB:0] == $past(cfg_in_use_ff.pll_source_in_use)))
    else $error("pll monitor read wrong");

  chk_power_read_live: assert property (
    s_pwr_settled ##0 s_read(`CPSM_OFS_PWR) |=> reg_rdata == $past(pwr_async))
    else $error("power monitor read does not show settled status");

  chk_pwr_write_ignored: assert property (
    (wr_go && (reg_req.addr == `CPSM_OFS_PWR)) ##1 s_read(`CPSM_OFS_PWR) ##0
      $stable(pwr_live_ff) |=> reg_rdata == $past(pwr_live_ff))
    else $error("power monitor changed by a write");

  chk_rsv_write_back: assert property (
    (wr_go && (reg_req.addr == `CPSM_OFS_PLL)) ##1 s_read(`CPSM_OFS_PLL) |=>
      (reg_rdata[`CPSM_PLL_RSV_LO_BIT] == $past(reg_req.wdata[`CPSM_PLL_RSV_LO_BIT], 2)))
    else $error("reserved pll bit does not read back");

  chk_unmapped_zero: assert property (
    rd_go && ((reg_req.addr < `CPSM_OFS_PUMP_DIV) || (reg_req.addr > `CPSM_OFS_PWR)) |=>
      reg_rdata == `CPSM_RD_UNMAPPED)
    else $error("unmapped read not zero");

  chk_rvalid_cause: assert property (
    $rose(reg_rvalid) |-> $past(rd_go))
    else $error("read answer without a read");

  // Oversample divider follows the same auto or programmed choice
  chk_osr_auto_pick: assert property (
    $past(rst_b) && $past(clk_en) |-> cfg_in_use_ff.oversample_divider_in_use ==
      ($past(auto_clock_en) ? $past(auto_cfg.oversample_divider_in_use)
                            : $past(manual_cfg.oversample_divider_in_use)))
    else $error("oversample divider in use does not follow auto set");

  // PLL state flop follows the enable one cycle later
  chk_pll_on_track: assert property (
    $past(rst_b) && $past(clk_en) |-> pll_on_status == $past(pll_enable))
    else $error("pll state does not follow the enable");

  // Settings, PLL state, power status, read data, answer and the reserved bit at 0x67 hold while the clock enable is low
  chk_freeze_hold: assert property (
    !clk_en |=> $stable(cfg_in_use_ff) && $stable(pll_on_ff) && $stable(pwr_live_ff) &&
      $stable(rdata_ff) && $stable(rvalid_ff) && $stable(rsv_pump_ff))
    else $error("state changed while frozen");

  // Settled power inputs reach the synchronised copy
  chk_pwr_live_settled: assert property (
    s_pwr_settled |-> pwr_live_ff == pwr_async)
    else $error("power status did not settle in time");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the register port answers
  ////////////////////////////////////////////////////////////////////////////

  // Read data stands until the next accepted read
  chk_rdata_holds: assert property (
    !rd_go |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // One answer per accepted read, none otherwise
  chk_rvalid_answer: assert property (
    clk_en |=> reg_rvalid == $past(reg_req.rd))
    else $error("read answer does not match the strobe");

  // Reserved bit 7 at 0x67 reads back the last write
  chk_pump_rsv_back: assert property (
    s_write(`CPSM_OFS_PUMP_DIV) ##1 s_read(`CPSM_OFS_PUMP_DIV) |=>
      (reg_rdata[`CPSM_DIV_RSV_BIT] == $past(reg_req.wdata[`CPSM_DIV_RSV_BIT], 2)))
    else $error("reserved pump bit does not read back");

  // Reserved bit 7 at 0x68 reads back the last write
  chk_osr_rsv_back: assert property (
    s_write(`CPSM_OFS_OSR_DIV) ##1 s_read(`CPSM_OFS_OSR_DIV) |=>
      (reg_rdata[`CPSM_DIV_RSV_BIT] == $past(reg_req.wdata[`CPSM_DIV_RSV_BIT], 2)))
    else $error("reserved oversample bit does not read back");

  // Reserved bits 7-5 at 0x69 read back the last write
  chk_pll_hi_back: assert property (
    s_write(`CPSM_OFS_PLL) ##1 s_read(`CPSM_OFS_PLL) |=>
      (reg_rdata[`CPSM_PLL_RSV_HI_MSB:`CPSM_PLL_RSV_HI_LSB] ==
        $past(reg_req.wdata[`CPSM_PLL_RSV_HI_MSB:`CPSM_PLL_RSV_HI_LSB], 2)))
    else $error("reserved pll high bits do not read back");

endmodule // cpsm_monitor

`default_nettype wire

//--- logic/cpsm_consts.svh
/*
  Offsets, bit positions and reset values of the clock and power status monitor.
  Assumes the includer only reads these macros; nothing here creates logic.
*/
`ifndef CPSM_CONSTS_SVH
`define CPSM_CONSTS_SVH

// Register offsets on the device control port
`define CPSM_OFS_PUMP_DIV 8'h67
`define CPSM_OFS_OSR_DIV 8'h68
`define CPSM_OFS_PLL 8'h69
`define CPSM_OFS_PWR 8'h6a

// Field positions
`define CPSM_DIV_MSB 6
`define CPSM_DIV_RSV_BIT 7
`define CPSM_PLL_RSV_HI_MSB 7
`define CPSM_PLL_RSV_HI_LSB 5
`define CPSM_PLL_ON_BIT 4
`define CPSM_PLL_RSV_LO_BIT 3
`define CPSM_PLL_SRC_MSB 2

// Reset values
`define CPSM_RST_RSV_BIT 1'h0
`define CPSM_RST_RSV_HI 3'h0
`define CPSM_RST_DIV 7'h00
`define CPSM_RST_SRC 3'h0
`define CPSM_RST_PWR 8'h00
`define CPSM_RST_SYNC 3'h0
`define CPSM_RST_BYTE 8'h00

// Value returned for an unmapped offset
`define CPSM_RD_UNMAPPED 8'h00

`endif

//--- logic/cpsm_pkg.sv
/*
  Types shared by the clock and power status monitor files.
  Assumes no other package; every user writes cpsm_pkg::name.
*/
`default_nettype none

package cpsm_pkg;

  // Clock settings, either derived automatically or programmed by software
  typedef struct packed {
    logic [6:0] pump_divider_in_use;      // Code n means divide by n+1
    logic [6:0] oversample_divider_in_use; // Code n means divide by n+1
    logic [2:0] pll_source_in_use;        // 0 pin clock, 1 bit clock, 2 internal clock, 3 gpio
  } cpsm_clk_cfg_t;

  // Power status of analog sub-blocks, 1 means active, MSB first as read
  typedef struct packed {
    logic pump_power_status;
    logic reference_power_status;
    logic line_driver_power_status;
    logic line_bias_power_status;
    logic line_feedback_power_status;
    logic left_stage_power_status;
    logic right_stage_power_status;
    logic converter_power_status;
  } cpsm_pwr_t;

  // Register access request from the control port engine
  typedef struct packed {
    logic [7:0] addr; // Register offset
    logic wr;         // Write strobe, one cycle
    logic rd;         // Read strobe, one cycle
    logic [7:0] wdata; // Write data
  } cpsm_req_t;

endpackage : cpsm_pkg

`default_nettype wire

//--- logic/cpsm_src_select.sv
/*
  Chooses between an automatically derived value and a programmed one.
  Assumes both candidates and the select come from logic on clk.
*/
`default_nettype none

module cpsm_src_select #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] RST_VAL = '0 // Value held while in reset
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic auto_en,
  input wire logic [WIDTH-1:0] auto_val,
  input wire logic [WIDTH-1:0] manual_val,
  output logic [WIDTH-1:0] in_use_ff
);

  logic [WIDTH-1:0] nxt_in_use; // Value actually applied next cycle

  // Auto setting wins while it is on, otherwise the programmed value
  always_comb begin
    nxt_in_use = auto_en ? auto_val : manual_val;
  end

  // Hold the value in use; frozen while the clock enable is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_use_ff <= RST_VAL;
    end else if (clk_en) begin
      in_use_ff <= nxt_in_use;
    end
  end

endmodule // cpsm_src_select

`default_nettype wire

//--- logic/cpsm_pin_sync.sv
/*
  Three-stage synchroniser for status levels from outside the clock domain.
  Assumes each bit is a slow level; a change counts once stages two and
  three agree, so a one-cycle glitch past stage one is dropped.
*/
`include "cpsm_consts.svh"
`default_nettype none

module cpsm_pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_ff
);

  genvar i;

  // One chain per status bit
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [2:0] stage_ff; // Stage 0 is read only by stage 1

      // Shift the level through three flops
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          stage_ff <= `CPSM_RST_SYNC;
        end else if (clk_en) begin
          stage_ff <= {stage_ff[1:0], async_in[i]};
        end
      end

      // Accept a new level only when stages two and three agree
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          level_ff[i] <= 1'b0;
        end else if (clk_en && (stage_ff[1] == stage_ff[2])) begin
          level_ff[i] <= stage_ff[2];
        end
      end
    end
  endgenerate

endmodule // cpsm_pin_sync

`default_nettype wire

//--- verif/cpsm_monitor_tb.sv
/*
  Self-checking bench for the clock and power status monitor registers.
  Assumes the design package and the constants header are compiled first,
  and that the bench alone drives every input of the monitor.
*/
`default_nettype none

module cpsm_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `include "cpsm_consts.svh"

  ////////////////////////////////////////////////////////////////////////
  // Signals and counters
  logic clk; // 100 MHz clock
  logic rst_b; // Asynchronous reset, active low
  logic clk_en; // Run enable
  logic auto_clock_en; // Automatic clock setting active
  logic pll_enable; // PLL enable level
  cpsm_pkg::cpsm_req_t reg_req; // Register strobes
  cpsm_pkg::cpsm_clk_cfg_t auto_cfg; // Automatically derived settings
  cpsm_pkg::cpsm_clk_cfg_t manual_cfg; // Programmed settings
  cpsm_pkg::cpsm_clk_cfg_t cfg_in_use; // Settings shown by the design
  cpsm_pkg::cpsm_clk_cfg_t exp; // Settings the bench expects
  cpsm_pkg::cpsm_pwr_t pwr_async; // Power status levels
  logic [7:0] reg_rdata; // Read data
  logic reg_rvalid; // Read answer
  logic pll_on_status; // Registered PLL state
  int num_errors; // Mismatches seen
  int num_checks; // Comparisons made
  int cycles; // Clock cycles since start

  ////////////////////////////////////////////////////////////////////////
  // Design under test
  cpsm_monitor u_cpsm_monitor (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .auto_clock_en(auto_clock_en),
    .auto_cfg(auto_cfg),
    .manual_cfg(manual_cfg),
    .pll_enable(pll_enable),
    .pwr_async(pwr_async),
    .cfg_in_use(cfg_in_use),
    .pll_on_status(pll_on_status)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hang short well past the expected run of about 285 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      $display("unexpected at %0t: run did not finish in time", $time);
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare tasks, one for each kind of result
  task automatic check_byte(input logic [7:0] got, input logic [7:0] want, input string what);
    num_checks++;
    if (got !== want) begin
      num_errors++;
      $display("unexpected at %0t: %s read %h, expected %h", $time, what, got, want);
    end
  endtask

  task automatic check_cfg(input logic [16:0] got, input logic [16:0] want);
    num_checks++;
    if (got !== want) begin
      num_errors++;
      $display("unexpected at %0t: settings %h, expected %h", $time, got, want);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Register access, entered and left at a falling edge
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Read strobe for one cycle, answer sampled one cycle later
  task automatic read_expect(input logic [7:0] addr, input logic [7:0] want, input string what);
    reg_req.addr = addr;
    reg_req.rd = 1'b1;
    @(negedge clk);
    reg_req.rd = 1'b0;
    check_byte({7'h00, reg_rvalid}, 8'h01, "read answer");
    check_byte(reg_rdata, want, what);
    @(negedge clk);
  endtask

  // Write strobe for one cycle; returns as it drops so a read can follow at once
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    reg_req.addr = addr;
    reg_req.wdata = data;
    reg_req.wr = 1'b1;
    @(negedge clk);
    reg_req.wr = 1'b0;
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    reg_req = '0;
    auto_clock_en = 1'b0;
    pll_enable = 1'b0;
    auto_cfg = '0;
    manual_cfg = '0;
    pwr_async = '0;
    exp = '0;
    num_errors = 0;
    num_checks = 0;
    cycles = 0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);

    // All fields zero with every source at zero
    read_expect(`CPSM_OFS_PUMP_DIV, 8'h00, "pump divider");
    read_expect(`CPSM_OFS_OSR_DIV, 8'h00, "oversample divider");
    read_expect(`CPSM_OFS_PLL, 8'h00, "pll state");
    read_expect(`CPSM_OFS_PWR, 8'h00, "power");
    $display("test reset values done");

    // Programmed settings for the first eight passes, automatic for the rest
    for (int i = 0; i < 16; i++) begin
      auto_cfg = {7'h7f - 7'(i[2:0]), 7'(i), 3'(i)};
      manual_cfg = {7'(i), 7'h7f - 7'(i), ~3'(i)};
      auto_clock_en = i[3];
      pll_enable = i[0];
      settle(3);
      exp = auto_clock_en ? auto_cfg : manual_cfg;
      check_cfg(cfg_in_use, exp);
      check_byte({7'h00, pll_on_status}, {7'h00, pll_enable}, "pll on");
      read_expect(`CPSM_OFS_PUMP_DIV, {1'b0, exp.pump_divider_in_use}, "pump");
      read_expect(`CPSM_OFS_OSR_DIV, {1'b0, exp.oversample_divider_in_use}, "osr");
      read_expect(`CPSM_OFS_PLL, {3'h0, pll_enable, 1'b0, exp.pll_source_in_use},
                  "pll");
    end
    $display("test clock selection done");

    // One sub-block active at a time, from charge pump down to converter
    for (int i = 0; i < 8; i++) begin
      pwr_async = 8'h80 >> i;
      settle(7);
      read_expect(`CPSM_OFS_PWR, 8'h80 >> i,
                  "power bit");
    end
    $display("test power status done");

    // Writes reach only the reserved bits; monitor fields keep their values
    reg_write(`CPSM_OFS_PUMP_DIV, 8'hff);
    read_expect(`CPSM_OFS_PUMP_DIV, {1'b1, exp.pump_divider_in_use}, "pump wr");
    reg_write(`CPSM_OFS_OSR_DIV, 8'h00);
    read_expect(`CPSM_OFS_OSR_DIV, {1'b0, exp.oversample_divider_in_use}, "osr wr");
    reg_write(`CPSM_OFS_PLL, 8'hff);
    read_expect(`CPSM_OFS_PLL, {3'h7, 1'b1, 1'b1, exp.pll_source_in_use}, "pll wr");
    reg_write(`CPSM_OFS_PWR, 8'hff);
    read_expect(`CPSM_OFS_PWR, 8'h01, "power wr");
    reg_write(8'h70, 8'hff);
    read_expect(8'h70, 8'h00, "unmapped");
    // A write while frozen is dropped
    clk_en = 1'b0;
    reg_write(`CPSM_OFS_PUMP_DIV, 8'h00);
    clk_en = 1'b1;
    read_expect(`CPSM_OFS_PUMP_DIV, {1'b1, exp.pump_divider_in_use}, "frozen wr");
    $display("test writes done");

    // Each read shows the level present at the time of the read
    pwr_async = 8'h5a;
    settle(7);
    read_expect(`CPSM_OFS_PWR, 8'h5a, "live one");
    pwr_async = 8'ha5;
    pll_enable = 1'b0;
    settle(7);
    read_expect(`CPSM_OFS_PWR, 8'ha5, "live two");
    read_expect(`CPSM_OFS_PLL, {3'h7, 1'b0, 1'b1, exp.pll_source_in_use}, "live pll");
    $display("test live reads done");
    results();
  end

endmodule // cpsm_monitor_tb

`default_nettype wire
